// *** verilog/breaker_failure_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 25 MHz clock, AXI4-Lite byte addresses.
// Notes: Delays are held in 5 ms steps.
`ifndef BREAKER_FAILURE_CFG_SVH
`define BREAKER_FAILURE_CFG_SVH
`define BF_CLK_PERIOD_NS 40
`define BF_STEP_NS 5000000
`define BF_TICK_CYCLES (`BF_STEP_NS / `BF_CLK_PERIOD_NS)
`define BF_STEP_US 5000
`define BF_DELAY_DEF_MS 200
`define RT_DELAY_DEF_MS 100
`define BF_DELAY_MAX_MS 1800000
`define BF_DELAY_DEF_STEPS ((`BF_DELAY_DEF_MS * 1000) / `BF_STEP_US)
`define RT_DELAY_DEF_STEPS ((`RT_DELAY_DEF_MS * 1000) / `BF_STEP_US)
`define BF_DELAY_MAX_STEPS ((`BF_DELAY_MAX_MS * 1000) / `BF_STEP_US)
`define BF_HIST_DEPTH 12
`define OFS_CTRL 8'h00
`define OFS_BFDELAY 8'h04
`define OFS_RTDELAY 8'h08
`define OFS_EVTSEL 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_LIVE 8'h18
`define OFS_CNT_A 8'h1C
`define OFS_CNT_B 8'h20
`define OFS_HIDX 8'h24
`define OFS_HW0 8'h28
`define OFS_HW1 8'h2C
`define OFS_HW2 8'h30
`define OFS_HW3 8'h34
`define CTRL_RETRIP_EN 0
`define CTRL_CUR_SUP 1
`define CTRL_DO_SUP 2
`define CTRL_CNT_CLR 3
`define CTRL_RESET 32'h0000_0001
`define EVTSEL_RESET 32'h0000_FFFF
`define MASK_RESET 32'h0000_0000
`endif

// *** verilog/breaker_failure_pkg.sv ***
// Purpose: Types shared by the breaker failure unit.
// Assumes: Delay counts fit 19 bits.
// Notes: Condition bit order is fixed by cond_t.
package breaker_failure_pkg;
  typedef logic [18:0] steps_t;
  typedef struct packed {
    logic [15:0] phaseCur;
    logic [15:0] resCur;
  } measure_t;
  // Bit 0 is start, bit 7 residual current
  typedef struct packed {
    logic resCur;
    logic phaseCur;
    logic signal;
    logic doMon;
    logic block;
    logic bfTrip;
    logic retrip;
    logic started;
  } cond_t;
  typedef struct packed {
    logic [31:0] stampMs;
    logic [3:0] eventCode;
    logic [2:0] group;
    measure_t meas;
    steps_t toRetrip;
    steps_t toFailure;
  } hist_rec_t;
  typedef enum logic [0:0] {
    W_IDLE = 1'b0,
    W_RESP = 1'b1
  } wr_state_t;
endpackage : breaker_failure_pkg

// *** verilog/history_ring.sv ***
// Purpose: Ring of the most recent operation records.
// Assumes: Index 0 reads the newest record.
// Notes: Oldest record is overwritten once full.
`timescale 1ns/1ps
module history_ring #(
  parameter int DEPTH = 12
) (
  input wire logic clk, // Device clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic wrEn, // Store one record
  input wire breaker_failure_pkg::hist_rec_t wrRec, // Record to store
  input wire logic [3:0] rdIdx, // Age of record to read
  output breaker_failure_pkg::hist_rec_t rdRec, // Selected record
  output logic [3:0] fill // Records held
);
  import breaker_failure_pkg::*;
  hist_rec_t mem [DEPTH];
  logic [3:0] head_reg;
  logic [3:0] fill_reg;
  logic [3:0] lastIdx;
  logic [4:0] rdSum;
  logic [3:0] rdPos;
  assign lastIdx = (head_reg == 4'h0) ? 4'(DEPTH - 1) : head_reg - 4'h1;
  assign rdSum = {1'b0, lastIdx} + 5'(DEPTH) - {1'b0, rdIdx};
  assign rdPos = (rdSum >= 5'(DEPTH)) ? 4'(rdSum - 5'(DEPTH)) : rdSum[3:0];
  assign rdRec = (rdIdx < fill_reg) ? mem[rdPos] : '0;
  assign fill = fill_reg;
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[head_reg] <= wrRec;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      head_reg <= 4'h0;
      fill_reg <= 4'h0;
    end else if (wrEn) begin
      head_reg <= (head_reg == 4'(DEPTH - 1)) ? 4'h0 : head_reg + 4'h1;
      fill_reg <= (fill_reg == 4'(DEPTH)) ? fill_reg : fill_reg + 4'h1;
    end
  end
  ring_fill_a: assert property (@(posedge clk) disable iff (!resetn)
    fill_reg <= 4'(DEPTH)) else $error("history fill above depth");
endmodule : history_ring

// *** verilog/breaker_failure_unit.sv ***
// Purpose: Dedicated breaker failure unit with AXI4-Lite registers.
// Assumes: Trip, output monitor and block arrive as asynchronous pins.
// Notes: Operation
`timescale 1ns/1ps
`include "breaker_failure_cfg.svh"
module breaker_failure_unit #(
  parameter int TICK_CYCLES = `BF_TICK_CYCLES
) (
  input wire logic clk, // 25 MHz device clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [31:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI
  output logic awready, // AXI
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI byte enables
  input wire logic wvalid, // AXI
  output logic wready, // AXI
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI
  input wire logic bready, // AXI
  input wire logic [31:0] araddr, // AXI read address
  input wire logic arvalid, // AXI
  output logic arready, // AXI
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI
  input wire logic rready, // AXI
  input wire logic tripPin, // Outside feeder trip, async
  input wire logic doMonitorPin, // Output contact monitor, async
  input wire logic blockPin, // Function block, async
  input wire logic phaseAbove, // Phase current over threshold
  input wire logic resAbove, // Residual current over threshold
  input wire breaker_failure_pkg::measure_t meas, // Live currents
  input wire logic [31:0] timeMs, // Wall time in ms
  input wire logic [2:0] settingGroup, // Active setting group
  output logic breakerFailureTrip, // Command to incoming breaker
  output logic redundantTrip, // Redundant trip output
  output breaker_failure_pkg::cond_t logicSignals, // Status to user logic
  output logic eventValid, // One-cycle event strobe
  output logic [7:0] eventOn, // ON events this strobe
  output logic [7:0] eventOff, // OFF events this strobe
  output logic [31:0] eventStamp, // Event time stamp
  output logic irq // Level interrupt
);
  import breaker_failure_pkg::*;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  function automatic logic [3:0] firstSet(input logic [7:0] v);
    logic [3:0] idx;
    idx = 4'hF;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : firstSet

  // Pins pass three flops; a change counts once stages two and three agree
  logic [2:0] pinRaw;
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [2:0] syncC_reg;
  logic [2:0] pinClean_reg;
  assign pinRaw = {blockPin, doMonitorPin, tripPin};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!resetn) begin
          syncA_reg[g] <= 1'b0;
          syncB_reg[g] <= 1'b0;
          syncC_reg[g] <= 1'b0;
          pinClean_reg[g] <= 1'b0;
        end else begin
          syncA_reg[g] <= pinRaw[g];
          syncB_reg[g] <= syncA_reg[g];
          syncC_reg[g] <= syncB_reg[g];
          if (syncB_reg[g] == syncC_reg[g]) begin
            pinClean_reg[g] <= syncC_reg[g];
          end
        end
      end
    end
  endgenerate
  logic tripIn;
  logic doMon;
  logic blockIn;
  assign tripIn = pinClean_reg[0];
  assign doMon = pinClean_reg[1];
  assign blockIn = pinClean_reg[2];

  // Registers
  logic [31:0] ctrl_reg;
  logic [31:0] bfDelay_reg;
  logic [31:0] rtDelay_reg;
  logic [31:0] evtSel_reg;
  logic [31:0] status_reg;
  logic [31:0] mask_reg;
  logic [3:0] histIdx_reg;
  logic [15:0] cntRetrip_reg;
  logic [15:0] cntFail_reg;
  logic [15:0] cntStart_reg;
  logic [15:0] cntBlock_reg;
  logic retripEn;
  logic curSup;
  logic doSup;
  steps_t bfDelay;
  steps_t rtDelay;
  assign retripEn = ctrl_reg[`CTRL_RETRIP_EN];
  assign curSup = ctrl_reg[`CTRL_CUR_SUP];
  assign doSup = ctrl_reg[`CTRL_DO_SUP];
  assign bfDelay = bfDelay_reg[18:0];
  assign rtDelay = rtDelay_reg[18:0];

  // Step tick, one pulse every 5 ms
  logic [31:0] tickCnt_reg;
  logic tick;
  assign tick = (tickCnt_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!resetn || tick) begin
      tickCnt_reg <= 32'h0000_0000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
    end
  end

  // Start only from the trip input, optionally gated by supervision
  logic start;
  assign start = tripIn && !blockIn
    && (!curSup || phaseAbove || resAbove)
    && (!doSup || doMon);

  // One step counter serves both delays
  steps_t stepCnt_reg;
  logic cntSat;
  assign cntSat = (stepCnt_reg == 19'h7_FFFF);
  always_ff @(posedge clk) begin
    if (!resetn || !start) begin
      stepCnt_reg <= 19'h0_0000;
    end else if (tick && !cntSat) begin
      stepCnt_reg <= stepCnt_reg + 19'h0_0001;
    end
  end
  logic bfReached;
  logic rtReached;
  steps_t toFailure;
  steps_t toRetrip;
  assign bfReached = start && (stepCnt_reg >= bfDelay);
  assign rtReached = start && retripEn && (stepCnt_reg >= rtDelay);
  assign toFailure = (bfDelay > stepCnt_reg) ? bfDelay - stepCnt_reg : 19'h0_0000;
  assign toRetrip = (rtDelay > stepCnt_reg) ? rtDelay - stepCnt_reg : 19'h0_0000;

  // Conditions and their edges
  cond_t cond_reg;
  cond_t prev_reg;
  logic [7:0] onEv;
  logic [7:0] offEv;
  logic [7:0] onKept;
  logic [7:0] offKept;
  assign onEv = cond_reg & ~prev_reg;
  assign offEv = ~cond_reg & prev_reg;
  assign onKept = onEv & evtSel_reg[7:0];
  assign offKept = offEv & evtSel_reg[15:8];
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cond_reg <= '0;
      prev_reg <= '0;
    end else begin
      cond_reg <= '{resCur: resAbove, phaseCur: phaseAbove, signal: tripIn, doMon: doMon,
                    block: blockIn, bfTrip: bfReached, retrip: rtReached, started: start};
      prev_reg <= cond_reg;
    end
  end
  assign breakerFailureTrip = cond_reg.bfTrip;
  assign redundantTrip = cond_reg.retrip;
  assign logicSignals = cond_reg;

  // Event buffer feed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      eventValid <= 1'b0;
      eventOn <= 8'h00;
      eventOff <= 8'h00;
      eventStamp <= 32'h0000_0000;
    end else begin
      eventValid <= |{onKept, offKept};
      eventOn <= onKept;
      eventOff <= offKept;
      eventStamp <= timeMs;
    end
  end

  // History records
  hist_rec_t histIn;
  hist_rec_t histOut;
  logic [3:0] histFill;
  logic histWr;
  assign histWr = |onEv;
  assign histIn = '{stampMs: timeMs, eventCode: firstSet(onEv), group: settingGroup,
                    meas: meas, toRetrip: toRetrip, toFailure: toFailure};
  history_ring #(.DEPTH(`BF_HIST_DEPTH)) u_hist (
    .clk(clk),
    .resetn(resetn),
    .wrEn(histWr),
    .wrRec(histIn),
    .rdIdx(histIdx_reg),
    .rdRec(histOut),
    .fill(histFill)
  );

  // AXI4-Lite write side
  wr_state_t wrState_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic wrHit;
  logic wrOk;
  logic awHigh_reg;
  assign doWrite = awHeld_reg && wHeld_reg && (wrState_reg == W_IDLE);
  // Upper address bits held with the offset; the bus may move once taken
  assign wrHit = (awAddr_reg <= `OFS_HW3) && (awAddr_reg[1:0] == 2'b00) && !awHigh_reg;
  assign wrOk = doWrite && wrHit;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrState_reg <= W_IDLE;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      awAddr_reg <= 8'h00;
      awHigh_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      case (wrState_reg)
        W_IDLE: begin
          if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr[7:0];
            awHigh_reg <= |awaddr[31:8];
          end
          if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
          end
          awready <= !(awHeld_reg || (awvalid && awready));
          wready <= !(wHeld_reg || (wvalid && wready));
          if (doWrite) begin
            wrState_reg <= W_RESP;
            bvalid <= 1'b1;
            bresp <= wrHit ? 2'b00 : 2'b10;
            awready <= 1'b0;
            wready <= 1'b0;
          end
        end
        W_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            wrState_reg <= W_IDLE;
          end
        end
        default: wrState_reg <= W_IDLE;
      endcase
    end
  end

  logic wrCtrl;
  logic wrStatus;
  logic cntClear;
  assign wrCtrl = wrOk && (awAddr_reg == `OFS_CTRL);
  assign wrStatus = wrOk && (awAddr_reg == `OFS_STATUS) && wStrb_reg[0] && wStrb_reg[1];
  assign cntClear = wrCtrl && wStrb_reg[0] && wData_reg[`CTRL_CNT_CLR];
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg <= `CTRL_RESET;
      bfDelay_reg <= 32'(`BF_DELAY_DEF_STEPS);
      rtDelay_reg <= 32'(`RT_DELAY_DEF_STEPS);
      evtSel_reg <= `EVTSEL_RESET;
      mask_reg <= `MASK_RESET;
      histIdx_reg <= 4'h0;
    end else if (wrOk) begin
      case (awAddr_reg)
        `OFS_CTRL: ctrl_reg <= mergeBytes(ctrl_reg, wData_reg, wStrb_reg) & 32'h0000_0007;
        `OFS_BFDELAY: begin
          // Out of range values are clamped to the top of the range
          if (mergeBytes(bfDelay_reg, wData_reg, wStrb_reg) > 32'(`BF_DELAY_MAX_STEPS)) begin
            bfDelay_reg <= 32'(`BF_DELAY_MAX_STEPS);
          end else begin
            bfDelay_reg <= mergeBytes(bfDelay_reg, wData_reg, wStrb_reg);
          end
        end
        `OFS_RTDELAY: begin
          if (mergeBytes(rtDelay_reg, wData_reg, wStrb_reg) > 32'(`BF_DELAY_MAX_STEPS)) begin
            rtDelay_reg <= 32'(`BF_DELAY_MAX_STEPS);
          end else begin
            rtDelay_reg <= mergeBytes(rtDelay_reg, wData_reg, wStrb_reg);
          end
        end
        `OFS_EVTSEL: evtSel_reg <= mergeBytes(evtSel_reg, wData_reg, wStrb_reg) & 32'h0000_FFFF;
        `OFS_MASK: mask_reg <= mergeBytes(mask_reg, wData_reg, wStrb_reg) & 32'h0000_FFFF;
        `OFS_HIDX: histIdx_reg <= wStrb_reg[0] ? wData_reg[3:0] : histIdx_reg;
        default: histIdx_reg <= histIdx_reg;
      endcase
    end
  end

  // Sticky event status; a new event wins over a clear
  logic [31:0] statusSet;
  assign statusSet = {16'h0000, offEv, onEv};
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_reg <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~(wrStatus ? wData_reg : 32'h0000_0000)) | statusSet;
      irq <= |(status_reg & mask_reg);
    end
  end

  // Counters saturate rather than wrap
  logic [3:0] cntInc;
  assign cntInc = {onEv[3], onEv[0], onEv[2], onEv[1]};
  always_ff @(posedge clk) begin
    if (!resetn || cntClear) begin
      cntRetrip_reg <= 16'h0000;
      cntFail_reg <= 16'h0000;
      cntStart_reg <= 16'h0000;
      cntBlock_reg <= 16'h0000;
    end else begin
      if (cntInc[0] && cntRetrip_reg != 16'hFFFF) begin
        cntRetrip_reg <= cntRetrip_reg + 16'h0001;
      end
      if (cntInc[1] && cntFail_reg != 16'hFFFF) cntFail_reg <= cntFail_reg + 16'h0001;
      if (cntInc[2] && cntStart_reg != 16'hFFFF) cntStart_reg <= cntStart_reg + 16'h0001;
      if (cntInc[3] && cntBlock_reg != 16'hFFFF) cntBlock_reg <= cntBlock_reg + 16'h0001;
    end
  end

  // AXI4-Lite read side
  logic [7:0] ra;
  logic rdHit;
  logic [31:0] rdMux;
  assign ra = araddr[7:0];
  assign rdHit = (ra <= `OFS_HW3) && (ra[1:0] == 2'b00) && (araddr[31:8] == 24'h00_0000);
  assign rdMux =
    (ra == `OFS_CTRL) ? ctrl_reg :
    (ra == `OFS_BFDELAY) ? bfDelay_reg :
    (ra == `OFS_RTDELAY) ? rtDelay_reg :
    (ra == `OFS_EVTSEL) ? evtSel_reg :
    (ra == `OFS_STATUS) ? status_reg :
    (ra == `OFS_MASK) ? mask_reg :
    (ra == `OFS_LIVE) ? {13'h0000, stepCnt_reg} | {24'h00_0000, cond_reg} << 24 :
    (ra == `OFS_CNT_A) ? {cntFail_reg, cntRetrip_reg} :
    (ra == `OFS_CNT_B) ? {cntBlock_reg, cntStart_reg} :
    (ra == `OFS_HIDX) ? {24'h00_0000, histFill, histIdx_reg} :
    (ra == `OFS_HW0) ? histOut.stampMs :
    (ra == `OFS_HW1) ? {histOut.eventCode, 25'h000_0000, histOut.group} :
    (ra == `OFS_HW2) ? histOut.meas :
    (ra == `OFS_HW3) ? {3'b000, histOut.toFailure[18:6], 3'b000, histOut.toRetrip[18:6]} :
    32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdHit ? rdMux : 32'h0000_0000;
      rresp <= rdHit ? 2'b00 : 2'b10;
    end else begin
      arready <= 1'b1;
    end
  end

  // Checks
  start_from_trip_a: assert property (@(posedge clk) disable iff (!resetn)
    cond_reg.started |-> $past(tripIn)) else $error("start without trip input");
  count_on_tick_a: assert property (@(posedge clk) disable iff (!resetn)
    start && tick && !cntSat ##1 start |-> stepCnt_reg == $past(stepCnt_reg) + 19'h0_0001)
    else $error("delay counter did not advance");
  fail_cmd_cause_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(breakerFailureTrip) |-> $past(start) && $past(stepCnt_reg) >= $past(bfDelay))
    else $error("failure command without elapsed delay");
  supervision_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    curSup && !phaseAbove && !resAbove |=> !cond_reg.started)
    else $error("start despite current supervision");
  event_status_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(breakerFailureTrip) |=> status_reg[2]) else $error("failure ON event missing");
  event_filter_a: assert property (@(posedge clk) disable iff (!resetn)
    eventValid |-> (({24'h00_0000, eventOn} & ~$past(evtSel_reg)) == 32'h0000_0000))
    else $error("unselected ON event stored");
  stamp_capture_a: assert property (@(posedge clk) disable iff (!resetn)
    eventValid |-> eventStamp == $past(timeMs)) else $error("event stamp wrong");
  fail_count_a: assert property (@(posedge clk) disable iff (!resetn)
    onEv[2] && !cntClear && cntFail_reg != 16'hFFFF |=>
    cntFail_reg == $past(cntFail_reg) + 16'h0001)
    else $error("failure counter missed event");
  history_write_a: assert property (@(posedge clk) disable iff (!resetn)
    histWr && histFill != 4'(`BF_HIST_DEPTH) |=> histFill == $past(histFill) + 4'h1)
    else $error("ON event not recorded");
  retrip_off_a: assert property (@(posedge clk) disable iff (!resetn)
    !retripEn |=> !redundantTrip) else $error("redundant trip while disabled");
  early_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    !start |=> stepCnt_reg == 19'h0_0000 && !breakerFailureTrip)
    else $error("counter kept after input drop");
  fail_seen_c: cover property (@(posedge clk) disable iff (!resetn) $rose(breakerFailureTrip));
  retrip_seen_c: cover property (@(posedge clk) disable iff (!resetn) $rose(redundantTrip));
  early_drop_c: cover property (@(posedge clk) disable iff (!resetn)
    $fell(start) && !breakerFailureTrip && stepCnt_reg != 19'h0_0000);
  irq_seen_c: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
endmodule : breaker_failure_unit

// *** verification/feeder_model.sv ***
// Purpose: Outgoing feeder protection side facing the unit's pins.
// Assumes: Commands come from the bench just after a rising edge.
// Notes: Contact monitor and residual current stay idle; phase current follows curCmd.
`timescale 1ns/1ps
module feeder_model (
  input wire logic clk, // Device clock
  input wire logic tripCmd, // Feeder protection trips
  input wire logic blockCmd, // Block request
  input wire logic curCmd, // Phase current above threshold
  output logic tripPin, // Trip to digital input
  output logic blockPin, // Block input
  output logic doMonitorPin, // Output contact monitor
  output logic phaseAbove, // Phase over threshold
  output logic resAbove, // Residual over threshold
  output breaker_failure_pkg::measure_t meas, // Live currents
  output logic [31:0] timeMs, // Wall time
  output logic [2:0] settingGroup // Group in use
);
  import breaker_failure_pkg::*;
  initial begin
    tripPin = 1'b0;
    blockPin = 1'b0;
    timeMs = 32'h0000_0000;
  end
  always @(posedge clk) begin
    tripPin <= tripCmd;
    blockPin <= blockCmd;
    timeMs <= timeMs + 32'h0000_0001;
  end
  // Contact monitor idle; phase current only when a scenario asks
  assign doMonitorPin = 1'b0;
  assign phaseAbove = curCmd;
  assign resAbove = 1'b0;
  // Moving currents so records do not hold constants
  assign meas = {timeMs[15:0], ~timeMs[15:0]};
  assign settingGroup = 3'h1;
endmodule : feeder_model

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the breaker failure unit.
// Assumes: Tick shortened to 4 cycles; pins pass a few filter stages.
// Notes: Scenarios run in order; counts depend on earlier scenarios.
`timescale 1ns/1ps
`include "breaker_failure_cfg.svh"
module tb;
  import breaker_failure_pkg::*;
  logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, tripCmd = 0, blockCmd = 0, curCmd = 0, evClr = 0;
  logic awready, wready, bvalid, arready, rvalid, tripPin, doMon, blockPin;
  logic phA, resA, bft, rtr, irq, ev;
  logic [1:0] rresp, bresp;
  logic [7:0] evOn, evOff;
  logic [15:0] evSeen = '0;
  cond_t ls;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, timeMs;
  logic [2:0] sg;
  measure_t meas;
  int nFail = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  // Gathers every reported event until a scenario clears it
  always @(posedge clk) begin
    if (evClr) evSeen <= 16'h0000;
    else if (ev === 1'b1) evSeen <= evSeen | {evOff, evOn};
  end
  feeder_model u_feeder_model (.clk(clk), .tripCmd(tripCmd), .blockCmd(blockCmd), .curCmd(curCmd),
    .tripPin(tripPin), .blockPin(blockPin), .doMonitorPin(doMon), .phaseAbove(phA),
    .resAbove(resA), .meas(meas), .timeMs(timeMs), .settingGroup(sg));
  breaker_failure_unit #(.TICK_CYCLES(4)) u_breaker_failure_unit (.clk(clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tripPin(tripPin), .doMonitorPin(doMon),
    .blockPin(blockPin), .phaseAbove(phA), .resAbove(resA), .meas(meas), .timeMs(timeMs),
    .settingGroup(sg), .breakerFailureTrip(bft), .redundantTrip(rtr), .logicSignals(ls),
    .eventValid(ev), .eventOn(evOn), .eventOff(evOff), .eventStamp(), .irq(irq));
  task final_report;
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (awready === 1 && !ta) begin
        ta = 1;
        awvalid <= 0;
      end
      if (wready === 1 && !tw) begin
        tw = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge clk); while (bvalid !== 1);
    bready <= 0;
  endtask : wr
  task chkRd(input logic [7:0] a, input logic [31:0] exp);
    araddr <= {24'h00_0000, a};
    arvalid <= 1;
    do @(posedge clk); while (arready !== 1);
    arvalid <= 0;
    rready <= 1;
    do @(posedge clk); while (rvalid !== 1);
    rready <= 0;
    chk(rdata, exp);
  endtask : chkRd
  task watch(input int n, output logic seen);
    seen = 0;
    repeat (n) begin @(posedge clk); seen = seen | bft | rtr; end
  endtask : watch
  task resetValues;
    chkRd(`OFS_CTRL, `CTRL_RESET);
    chkRd(`OFS_BFDELAY, `BF_DELAY_DEF_STEPS);
    chkRd(`OFS_RTDELAY, `RT_DELAY_DEF_STEPS);
    chkRd(`OFS_EVTSEL, `EVTSEL_RESET);
    chkRd(`OFS_MASK, `MASK_RESET);
    chkRd(8'h40, 32'h0000_0000);
    chk(rresp, 32'h0000_0002);
    wr(8'h40, 32'h0000_0000);
    chk(bresp, 32'h0000_0002);
  endtask : resetValues
  task delayTrip;
    int n;
    wr(`OFS_BFDELAY, 32'h0000_0003);
    wr(`OFS_RTDELAY, 32'h0000_0002);
    chk(bresp, 32'h0000_0000);
    tripCmd <= 1;
    n = 0;
    while (bft !== 1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 8 && n <= 24, 32'h0000_0001);
    chk(rtr, 32'h0000_0001);
    chk(ls, 32'h0000_0027);
    tripCmd <= 0;
    repeat (10) @(posedge clk);
    chk(bft, 32'h0000_0000);
  endtask : delayTrip
  task shortTrip;
    logic seen;
    tripCmd <= 1;
    repeat (3) @(posedge clk);
    tripCmd <= 0;
    watch(40, seen);
    chk(seen, 32'h0000_0000);
  endtask : shortTrip
  task blocked;
    logic seen;
    blockCmd <= 1;
    repeat (6) @(posedge clk);
    tripCmd <= 1;
    watch(40, seen);
    chk(seen, 32'h0000_0000);
    tripCmd <= 0;
    blockCmd <= 0;
    repeat (8) @(posedge clk);
  endtask : blocked
  task counters;
    chkRd(`OFS_CNT_A, 32'h0001_0001);
    chkRd(`OFS_CNT_B, 32'h0001_0002);
    wr(`OFS_CTRL, 32'h0000_0009);
    chkRd(`OFS_CNT_A, 32'h0000_0000);
    chkRd(`OFS_CTRL, 32'h0000_0001);
  endtask : counters
  task irqFlow;
    chk(irq, 32'h0000_0000);
    chkRd(`OFS_STATUS, 32'h0000_2F2F);
    chk(evSeen, 32'h0000_2F2F);
    wr(`OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0000_0001);
    wr(`OFS_STATUS, 32'h0000_2F2F);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0000_0000);
    chkRd(`OFS_STATUS, 32'h0000_0000);
  endtask : irqFlow
  // Thirteen records in all, so the oldest one has been overwritten
  task history;
    wr(`OFS_BFDELAY, 32'h0000_0081);
    wr(`OFS_RTDELAY, 32'h0000_0041);
    repeat (7) shortTrip;
    chkRd(`OFS_HIDX, 32'h0000_00C0);
    chkRd(`OFS_HW1, 32'h0000_0001);
    chkRd(`OFS_HW3, 32'h0002_0001);
    wr(`OFS_HIDX, 32'h0000_000B);
    chkRd(`OFS_HW1, 32'h1000_0001);
  endtask : history
  task supervised;
    logic seen;
    wr(`OFS_EVTSEL, 32'h0000_00FF);
    wr(`OFS_BFDELAY, 32'h0000_0003);
    wr(`OFS_CTRL, 32'h0000_0002);
    evClr <= 1;
    tripCmd <= 1;
    @(posedge clk);
    evClr <= 0;
    watch(40, seen);
    chk(seen, 32'h0000_0000);
    curCmd <= 1;
    watch(30, seen);
    chk(seen, 32'h0000_0001);
    tripCmd <= 0;
    curCmd <= 0;
    repeat (10) @(posedge clk);
    chk(evSeen, 32'h0000_0065);
  endtask : supervised
  // Whole run needs about six hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    repeat (2) @(posedge clk);
    resetValues;
    delayTrip;
    shortTrip;
    blocked;
    counters;
    irqFlow;
    history;
    supervised;
    final_report;
  end
endmodule : tb
